// ==== shared/aux_clk_map.vh ====
// register map, field positions, reset values and timing counts for the aux clock control block
`ifndef AUX_CLK_MAP_VH
`define AUX_CLK_MAP_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ACD_CTRL_ADDR 12'h000
`define ACD_IRQ_STATUS_ADDR 12'h004
`define ACD_IRQ_MASK_ADDR 12'h008
// ----------------------------------------
// control register fields
// ----------------------------------------
`define ACD_ENABLE_BIT 15
`define ACD_LOCK_BIT 14
`define ACD_DIVSRC_BIT 13
`define ACD_RATIO_HI 10
`define ACD_RATIO_LO 8
`define ACD_REFSRC_BIT 7
`define ACD_RCSEL_BIT 6
`define ACD_CTRL_WMASK 16'ha7c0
// ----------------------------------------
// reset values
// ----------------------------------------
`define ACD_ENABLE_RST 1'h0
`define ACD_DIVSRC_RST 1'h1
`define ACD_RATIO_RST 3'h7
`define ACD_REFSRC_RST 1'h0
`define ACD_RCSEL_RST 1'h0
// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define ACD_IRQ_LOCK_GAIN 0
`define ACD_IRQ_LOCK_LOSS 1
`define ACD_IRQ_W 2
// ----------------------------------------
// timing
// ----------------------------------------
`define ACD_CLK_NS 50
`define ACD_LOCK_NS 100000
`define ACD_LOCK_CYCLES ((`ACD_LOCK_NS + `ACD_CLK_NS - 1) / `ACD_CLK_NS)
`endif

// ==== verilog/aux_ratio_divider.v ====
// power-of-two enable divider for the auxiliary clock output
`timescale 1ns/1ps
module aux_ratio_divider #(
  parameter CNT_W = 6 // enough for divide by 64
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire run, // divider runs while high
  input wire [2:0] ratio, // output ratio code
  // output
  output reg tick_q // one-cycle enable at the divided rate
);

  reg [CNT_W-1:0] cnt_q; // free count inside one period
  reg [CNT_W-1:0] last; // terminal count for the code

  // ----------------------------------------
  // ratio decode
  // ----------------------------------------
  // code 111 divides by 1, each step down doubles; 000 treated as 64
  always @* begin
    case (ratio)
      3'h7: last = 6'h00;
      3'h6: last = 6'h01;
      3'h5: last = 6'h03;
      3'h4: last = 6'h07;
      3'h3: last = 6'h0f;
      3'h2: last = 6'h1f;
      default: last = 6'h3f;
    endcase
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // restarts whenever the source stops, so the first tick is a full period late
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      tick_q <= 1'b0;
    end
  end

endmodule

// ==== verilog/aux_clock_divisor_control.v ====
// auxiliary clock path control: pll reference, enable, lock, divider source and ratio
// Contract
// RQ1: pll runs only while enable bit set
// RQ2: read-only lock flag mirrors pll lock; here set only after 2000 cycles of pll lock while running on a live reference
// RQ3: divider source select picks oscillator or pll
// RQ4: ratio field divides by powers of two
// RQ5: reference select picks primary oscillator or none
// RQ6: rc select overrides reference for pll input
// RQ7: control register reset by power-on only
// RQ8: unimplemented bits read zero, ignore writes
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "aux_clk_map.vh"
module aux_clock_divisor_control (
  // bus clock and resets
  input wire hclk,
  input wire hresetn, // system reset, all sources
  input wire por_n, // power-on reset only, active low
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // clock sources present
  input wire fast_internal_rc_ok, // internal rc oscillator running
  input wire primary_osc_ok, // primary oscillator running
  input wire aux_osc_ok, // auxiliary oscillator path running
  // pll interface
  input wire aux_pll_locked, // raw lock indication from the pll
  output reg aux_pll_run_q, // pll enable
  output reg [1:0] aux_pll_ref_q, // 0 none, 1 primary, 2 internal rc
  output reg aux_div_from_osc_q, // divider fed by oscillator path
  output wire aux_clk_tick, // divided auxiliary clock enable
  // interrupt
  output wire irq
);

  // ----------------------------------------
  // local state
  // ----------------------------------------
  localparam LOCK_CYCLES = `ACD_LOCK_CYCLES; // settle time modelled before lock trusted
  localparam integer LOCK_LAST_I = LOCK_CYCLES - 1; // full-width terminal count
  localparam [12:0] LOCK_LAST = LOCK_LAST_I[12:0]; // counter is 13 bits, 2000 fits

  reg aux_pll_enable_q; // enable bit
  reg aux_divider_source_select_q; // divider source bit
  reg [2:0] aux_output_ratio_q; // ratio field
  reg aux_reference_source_select_q; // reference source bit
  reg internal_rc_reference_select_q; // rc select bit
  reg aux_pll_lock_flag_q; // lock state as software sees it
  reg [12:0] settle_q; // lock settle counter
  reg [`ACD_IRQ_W-1:0] irq_status_q; // sticky events
  reg [`ACD_IRQ_W-1:0] irq_mask_q; // event enables
  reg wr_pend_q; // write data phase pending
  reg rd_pend_q; // read data phase pending
  reg [11:0] addr_q; // latched address phase
  wire addr_take; // valid address phase
  wire ref_ok; // selected reference is alive
  wire div_src_ok; // selected divider source is alive
  wire [15:0] ctrl_rd; // control register read image
  wire [`ACD_IRQ_W-1:0] events; // this cycle's events

  // ----------------------------------------
  // bus helpers
  // ----------------------------------------
  function sel_match;
    input [11:0] a;
    input [11:0] target;
    begin
      sel_match = (a[11:2] == target[11:2]);
    end
  endfunction

  assign addr_take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1; // zero wait states, write data lands at end of data phase
  assign hresp = 1'b0; // always okay

  // ----------------------------------------
  // address phase capture
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else if (hready) begin
      wr_pend_q <= addr_take && hwrite;
      rd_pend_q <= addr_take && !hwrite;
      if (addr_take) begin
        addr_q <= haddr;
      end
    end
  end

  // ----------------------------------------
  // control register, power-on domain
  // ----------------------------------------
  // only por_n resets these; a system reset leaves software's settings alone
  always @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      aux_pll_enable_q <= `ACD_ENABLE_RST; // see RQ7
      aux_divider_source_select_q <= `ACD_DIVSRC_RST;
      aux_output_ratio_q <= `ACD_RATIO_RST;
      aux_reference_source_select_q <= `ACD_REFSRC_RST;
      internal_rc_reference_select_q <= `ACD_RCSEL_RST;
    end else if (wr_pend_q && sel_match(addr_q, `ACD_CTRL_ADDR)) begin
      // only implemented bits are stored; lock bit is read-only
      aux_pll_enable_q <= hwdata[`ACD_ENABLE_BIT]; // see RQ8
      aux_divider_source_select_q <= hwdata[`ACD_DIVSRC_BIT];
      aux_output_ratio_q <= hwdata[`ACD_RATIO_HI:`ACD_RATIO_LO];
      aux_reference_source_select_q <= hwdata[`ACD_REFSRC_BIT];
      internal_rc_reference_select_q <= hwdata[`ACD_RCSEL_BIT];
    end
  end

  // ----------------------------------------
  // pll steering outputs
  // ----------------------------------------
  // registered so the pll and muxes see glitch-free selects
  always @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      aux_pll_run_q <= 1'b0;
      aux_pll_ref_q <= 2'h0;
      aux_div_from_osc_q <= 1'b1;
    end else begin
      aux_pll_run_q <= aux_pll_enable_q; // see RQ1
      if (internal_rc_reference_select_q) begin
        aux_pll_ref_q <= 2'h2; // see RQ6
      end else if (aux_reference_source_select_q) begin
        aux_pll_ref_q <= 2'h1; // see RQ5
      end else begin
        aux_pll_ref_q <= 2'h0; // no reference selected
      end
      aux_div_from_osc_q <= aux_divider_source_select_q; // see RQ3
    end
  end

  assign ref_ok = (aux_pll_ref_q == 2'h2) ? fast_internal_rc_ok :
                  (aux_pll_ref_q == 2'h1) ? primary_osc_ok : 1'b0;

  // ----------------------------------------
  // lock tracking
  // ----------------------------------------
  // lock is believed only after the pll reports lock for a settle time;
  // a disabled pll or dead reference drops it at once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q <= 13'h0000;
      aux_pll_lock_flag_q <= 1'b0;
    end else if (!aux_pll_run_q || !ref_ok || !aux_pll_locked) begin
      settle_q <= 13'h0000;
      aux_pll_lock_flag_q <= 1'b0; // see RQ2
    end else if (settle_q >= LOCK_LAST) begin
      aux_pll_lock_flag_q <= 1'b1; // see RQ2
    end else begin
      settle_q <= settle_q + 13'h0001;
    end
  end

  // ----------------------------------------
  // output divider
  // ----------------------------------------
  // divider runs from oscillator path, or from the pll once it is locked
  assign div_src_ok = aux_div_from_osc_q ? aux_osc_ok : aux_pll_lock_flag_q;

  aux_ratio_divider #(
    .CNT_W(6)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(div_src_ok),
    .ratio(aux_output_ratio_q), // see RQ4
    .tick_q(aux_clk_tick)
  );

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  reg lock_prev_q; // lock flag one cycle ago
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= aux_pll_lock_flag_q;
    end
  end

  assign events = {lock_prev_q && !aux_pll_lock_flag_q, !lock_prev_q && aux_pll_lock_flag_q};

  // set wins over a write-one clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      if (wr_pend_q && sel_match(addr_q, `ACD_IRQ_STATUS_ADDR)) begin
        irq_status_q <= (irq_status_q & ~hwdata[`ACD_IRQ_W-1:0]) | events;
      end else begin
        irq_status_q <= irq_status_q | events;
      end
      if (wr_pend_q && sel_match(addr_q, `ACD_IRQ_MASK_ADDR)) begin
        irq_mask_q <= hwdata[`ACD_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ----------------------------------------
  // read data
  // ----------------------------------------
  assign ctrl_rd = {aux_pll_enable_q, aux_pll_lock_flag_q, aux_divider_source_select_q,
                    2'h0, aux_output_ratio_q, aux_reference_source_select_q,
                    internal_rc_reference_select_q, 6'h00}; // see RQ8

  // data registered in the address phase so it stands through the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      if (sel_match(haddr, `ACD_CTRL_ADDR)) begin
        hrdata <= {16'h0000, ctrl_rd};
      end else if (sel_match(haddr, `ACD_IRQ_STATUS_ADDR)) begin
        hrdata <= {30'h00000000, irq_status_q};
      end else if (sel_match(haddr, `ACD_IRQ_MASK_ADDR)) begin
        hrdata <= {30'h00000000, irq_mask_q};
      end else begin
        hrdata <= 32'h00000000; // unmapped reads zero
      end
    end
  end

endmodule

// ==== dv/aux_clk_checker.sv ====
// port-level assertions for the aux clock control block
`timescale 1ns/1ps
`include "aux_clk_map.vh"
module aux_clk_checker (
  // clock and resets
  input wire hclk,
  input wire hresetn,
  input wire por_n,
  // bus
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hready,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  // clock path
  input wire aux_osc_ok,
  input wire aux_pll_locked,
  input wire aux_pll_run_q,
  input wire [1:0] aux_pll_ref_q,
  input wire aux_div_from_osc_q,
  input wire aux_clk_tick,
  input wire irq
);
  // data phase flags: ctrl write, ctrl read, unmapped read
  reg wr_q;
  reg rd_q;
  reg rz_q;
  wire take = hsel && hready && htrans[1];
  // track which transfer owns the current data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rz_q <= 1'b0;
    end else begin
      wr_q <= take && hwrite && haddr == `ACD_CTRL_ADDR;
      rd_q <= take && !hwrite && haddr == `ACD_CTRL_ADDR;
      rz_q <= take && !hwrite && haddr > `ACD_IRQ_MASK_ADDR;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn || !por_n);
  // steering only moves two edges after a control write
  chk_steer_cause: assert property (
    $changed({aux_pll_run_q, aux_pll_ref_q, aux_div_from_osc_q}) |-> $past(wr_q, 2))
    else $error("steering changed without a control write");
  chk_run_value: assert property (
    $past(wr_q, 2) |-> aux_pll_run_q == $past(hwdata[15], 2))
    else $error("pll run differs from written enable");
  chk_div_value: assert property (
    $past(wr_q, 2) |-> aux_div_from_osc_q == $past(hwdata[13], 2))
    else $error("divider source differs from written select");
  // rc select overrides the reference select
  chk_ref_value: assert property (
    $past(wr_q, 2) |-> aux_pll_ref_q ==
      ($past(hwdata[6], 2) ? 2'h2 : {1'b0, $past(hwdata[7], 2)}))
    else $error("pll reference differs from written selects");
  chk_ctrl_unimpl: assert property (
    rd_q |-> (hrdata & 32'hffff183f) == 32'h0)
    else $error("unimplemented control bits read nonzero");
  chk_unmapped_zero: assert property (rz_q |-> hrdata == 32'h0)
    else $error("unmapped read nonzero");
  chk_lock_cause: assert property (
    rd_q && hrdata[14] |-> $past(aux_pll_locked, 2) && $past(aux_pll_run_q, 2))
    else $error("lock flag set without a running locked pll");
  chk_tick_halt: assert property (
    (aux_div_from_osc_q && !aux_osc_ok) [*3] |-> !aux_clk_tick)
    else $error("tick without its oscillator source");
  cover property (wr_q);
  cover property ($rose(irq));
  cover property (aux_clk_tick);
endmodule
bind aux_clock_divisor_control aux_clk_checker u_chk (.hclk, .hresetn, .por_n, .hsel,
  .haddr, .htrans, .hready, .hwrite, .hwdata, .hrdata, .aux_osc_ok, .aux_pll_locked,
  .aux_pll_run_q, .aux_pll_ref_q, .aux_div_from_osc_q, .aux_clk_tick, .irq);

// ==== dv/testbench.sv ====
// self-checking bench for the aux clock control block
`timescale 1ns/1ps
`include "aux_clk_map.vh"
module testbench;
  localparam [11:0] ctl = `ACD_CTRL_ADDR;
  localparam [11:0] sta = `ACD_IRQ_STATUS_ADDR;
  localparam [11:0] msk = `ACD_IRQ_MASK_ADDR;
  reg hclk;
  reg hresetn;
  reg por_n;
  reg hsel;
  reg hwrite;
  reg [11:0] haddr;
  reg [1:0] htrans;
  reg [31:0] hwdata;
  reg rc_ok;
  reg pri_ok;
  reg osc_ok;
  reg locked;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire run;
  wire [1:0] ref_q;
  wire div;
  wire tick;
  wire irq;
  integer fails;
  integer checks;
  integer i;
  integer n;
  reg [31:0] rd;
  // row: tick gap, pll reference code, control value
  reg [31:0] row [0:6];
  aux_clock_divisor_control u_dut (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fast_internal_rc_ok(rc_ok), .primary_osc_ok(pri_ok), .aux_osc_ok(osc_ok),
    .aux_pll_locked(locked), .aux_pll_run_q(run), .aux_pll_ref_q(ref_q),
    .aux_div_from_osc_q(div), .aux_clk_tick(tick), .irq(irq)
  );
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // watchdog, well beyond the expected few thousand cycles
  initial begin
    #1000000;
    fails = fails + 1;
    print_verdict;
  end
  task ck(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one single transfer; read data kept in rd
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= a;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  // cycles up to the next tick, bounded
  task gap;
    begin
      n = 0;
      do begin
        @(posedge hclk);
        #1;
        n = n + 1;
      end while (tick !== 1'b1 && n < 200);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    hresetn = 1'b0;
    por_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwdata = 32'h0;
    rc_ok = 1'b1;
    pri_ok = 1'b1;
    osc_ok = 1'b0;
    locked = 1'b0;
    fails = 0;
    checks = 0;
    row[0] = 32'h0102a7c0;
    row[1] = 32'h02012680;
    row[2] = 32'h04022540;
    row[3] = 32'h0800a400;
    row[4] = 32'h10012380;
    row[5] = 32'h200222c0;
    row[6] = 32'h40002100;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge hclk);
    osc_ok <= 1'b1;
    // junk in unimplemented bits must not stick
    for (i = 0; i < 7; i = i + 1) begin
      xfer(1'b1, ctl, {16'h0, row[i][15:0] | 16'h583f});
      xfer(1'b0, ctl, 32'h0);
      ck("ctrl", {16'h0, row[i][15:0]}, rd);
      ck("run", row[i][15], run);
      ck("ref", row[i][17:16], ref_q);
      ck("div src", 1, div);
      gap;
      gap;
      gap;
      ck("tick gap", row[i][31:24], n);
    end
    // lock from primary oscillator, gain event unmasked
    xfer(1'b1, msk, 32'h1);
    xfer(1'b1, ctl, 32'h8780);
    locked <= 1'b1;
    repeat (`ACD_LOCK_CYCLES + 20) @(posedge hclk);
    xfer(1'b0, ctl, 32'h0);
    ck("locked", 32'hc780, rd);
    ck("div src", 0, div);
    ck("irq gain", 1, irq);
    xfer(1'b1, sta, 32'h1);
    @(posedge hclk);
    locked <= 1'b0;
    ck("irq clr", 0, irq);
    xfer(1'b0, ctl, 32'h0);
    ck("unlocked", 32'h8780, rd);
    ck("irq masked", 0, irq);
    xfer(1'b1, msk, 32'h3);
    xfer(1'b0, sta, 32'h0);
    ck("status", 32'h2, rd);
    ck("irq loss", 1, irq);
    // system reset keeps control, power-on restores it
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, ctl, 32'h0);
    ck("kept", 32'h8780, rd);
    @(posedge hclk);
    por_n <= 1'b0;
    repeat (2) @(posedge hclk);
    por_n <= 1'b1;
    xfer(1'b0, ctl, 32'h0);
    ck("por ctrl", 32'h2700, rd);
    ck("por out", 32'h1, {run, ref_q, div});
    xfer(1'b1, 12'h00c, 32'hffffffff);
    xfer(1'b0, 12'h00c, 32'h0);
    ck("unmapped", 32'h0, rd);
    ck("hresp", 32'h0, hresp);
    print_verdict;
  end
endmodule
